// ===== ofd_pkg.sv
// Package with field codes, select encodings and decoded-operand structs
package ofd_pkg;

   // ======================================================================
   // Operand register select codes
   // ======================================================================
   typedef enum logic [4:0] {
      OFD_SEL_NONE = 5'h00,
      OFD_SEL_XL = 5'h01,
      OFD_SEL_XH = 5'h02,
      OFD_SEL_YL = 5'h03,
      OFD_SEL_YH = 5'h04,
      OFD_SEL_X = 5'h05,
      OFD_SEL_Y = 5'h06,
      OFD_SEL_ACC_A = 5'h07,
      OFD_SEL_ACC_B = 5'h08,
      OFD_SEL_A_LOW = 5'h09,
      OFD_SEL_A_MID = 5'h0A,
      OFD_SEL_A_EXT = 5'h0B,
      OFD_SEL_B_LOW = 5'h0C,
      OFD_SEL_B_MID = 5'h0D,
      OFD_SEL_B_EXT = 5'h0E,
      OFD_SEL_AB = 5'h0F,
      OFD_SEL_BA = 5'h10,
      OFD_SEL_A10 = 5'h11,
      OFD_SEL_B10 = 5'h12
   } ofd_opnd_e;

   // ======================================================================
   // Effective-address modes
   // ======================================================================
   typedef enum logic [3:0] {
      OFD_EA_POSTDEC_OFS = 4'h0,
      OFD_EA_POSTINC_OFS = 4'h1,
      OFD_EA_POSTDEC = 4'h2,
      OFD_EA_POSTINC = 4'h3,
      OFD_EA_NOUPD = 4'h4,
      OFD_EA_INDEXED = 4'h5,
      OFD_EA_PREDEC = 4'h6,
      OFD_EA_ABSOLUTE = 4'h7,
      OFD_EA_IMMEDIATE = 4'h8,
      OFD_EA_INVALID = 4'hF
   } ofd_ea_mode_e;

   // ======================================================================
   // On-chip register groups
   // ======================================================================
   typedef enum logic [3:0] {
      OFD_GRP_NONE = 4'h0,
      OFD_GRP_ALU_IN = 4'h1,
      OFD_GRP_ACC = 4'h2,
      OFD_GRP_PTR = 4'h3,
      OFD_GRP_OFS = 4'h4,
      OFD_GRP_MOD = 4'h5,
      OFD_GRP_EXT_PTR = 4'h6,
      OFD_GRP_CTL2 = 4'h7,
      OFD_GRP_CTL8 = 4'h8
   } ofd_grp_e;

   // Controller register codes within the eight-register, two-register and extension-pointer groups
   localparam logic [3:0] OFD_CTL_STACK_SIZE = 4'h0;
   localparam logic [3:0] OFD_CTL_STATUS_WORD = 4'h1;
   localparam logic [3:0] OFD_CTL_OPMODE_WORD = 4'h2;
   localparam logic [3:0] OFD_CTL_STACK_PTR = 4'h3;
   localparam logic [3:0] OFD_CTL_STACK_TOP_HIGH = 4'h4;
   localparam logic [3:0] OFD_CTL_STACK_TOP_LOW = 4'h5;
   localparam logic [3:0] OFD_CTL_LOOP_ADDRESS = 4'h6;
   localparam logic [3:0] OFD_CTL_LOOP_COUNTER = 4'h7;
   localparam logic [3:0] OFD_CTL_VECTOR_BASE = 4'h8;
   localparam logic [3:0] OFD_CTL_SIZE_COUNTER = 4'h9;
   localparam logic [3:0] OFD_CTL_STACK_EXT_PTR = 4'hA;

   // Field codes
   localparam logic [5:0] OFD_EA_ABS_CODE = 6'h30;
   localparam logic [5:0] OFD_EA_IMM_CODE = 6'h34;
   localparam logic [2:0] OFD_EA_MODE_ABSIMM = 3'h6;
   localparam logic [2:0] OFD_EXT_PTR_CODE = 3'h2;
   localparam logic [3:0] OFD_ALU_IN_PREFIX = 4'h1;

   // ======================================================================
   // Raw instruction fields, all arrive together with a valid strobe
   // ======================================================================
   typedef struct packed {
      logic valid;
      logic dest_acc;
      logic data_pair;
      logic [1:0] src_two;
      logic [2:0] src_sel;
      logic [2:0] par1;
      logic [2:0] par2;
      logic [2:0] par3;
      logic [1:0] pcu_byte;
      logic [5:0] ea1;
      logic [5:0] ea2;
      logic [5:0] ea3;
      logic [4:0] ea_short;
      logic mem_space;
      logic [5:0] reg6;
      logic [2:0] long_move;
      logic [3:0] addr_dest;
      logic [2:0] mult_pair;
      logic [1:0] mult_one;
      logic [1:0] mult_alt;
      logic mult_sign;
      logic [3:0] mult_wide;
   } ofd_fields_s;

   // Decoded effective address
   typedef struct packed {
      ofd_ea_mode_e mode;
      logic [2:0] ptr;
      logic illegal;
   } ofd_ea_s;

   // Decoded long move
   typedef struct packed {
      ofd_opnd_e pair;
      logic limit_src;
      logic sign_ext;
      logic zero_fill;
   } ofd_long_s;

   // Decoded outputs
   typedef struct packed {
      logic valid;
      ofd_opnd_e dest_acc;
      ofd_opnd_e data_pair;
      ofd_opnd_e src_two;
      ofd_opnd_e src_sel;
      ofd_opnd_e par1;
      ofd_opnd_e par2;
      ofd_opnd_e par3;
      logic [1:0] pcu_byte;
      ofd_ea_s ea1;
      ofd_ea_s ea2;
      ofd_ea_s ea3;
      ofd_ea_s ea_short;
      logic mem_y;
      ofd_grp_e reg_grp;
      logic [3:0] reg_idx;
      ofd_long_s long_move;
      logic addr_is_ofs;
      logic [2:0] addr_idx;
      ofd_opnd_e mul_a;
      ofd_opnd_e mul_b;
      ofd_opnd_e mul_one;
      ofd_opnd_e mul_alt;
      logic negate;
      ofd_opnd_e wmul_a;
      ofd_opnd_e wmul_b;
      logic illegal;
   } ofd_dec_s;

endpackage : ofd_pkg

// ===== ofd_ea_decode.sv
// Effective-address field decoder, one instance per field variant
`timescale 1ns/10ps
module ofd_ea_decode #(
   parameter bit ALLOW_ABS = 1'b1, // Absolute address code accepted
   parameter bit ALLOW_IMM = 1'b1 // Immediate data code accepted
) (
   input wire logic [5:0] field, // Mode bits 5:3, pointer bits 2:0
   output ofd_pkg::ofd_ea_s dec // Decoded mode and pointer
);

   always_comb begin
      dec.ptr = field[2:0];
      dec.illegal = 1'b0;
      unique case (field[5:3])
         3'h0: dec.mode = ofd_pkg::OFD_EA_POSTDEC_OFS;
         3'h1: dec.mode = ofd_pkg::OFD_EA_POSTINC_OFS;
         3'h2: dec.mode = ofd_pkg::OFD_EA_POSTDEC;
         3'h3: dec.mode = ofd_pkg::OFD_EA_POSTINC;
         3'h4: dec.mode = ofd_pkg::OFD_EA_NOUPD;
         3'h5: dec.mode = ofd_pkg::OFD_EA_INDEXED;
         3'h7: dec.mode = ofd_pkg::OFD_EA_PREDEC;
         3'h6: begin
            dec.mode = ofd_pkg::OFD_EA_INVALID;
            dec.illegal = 1'b1;
            if (ALLOW_ABS && field == ofd_pkg::OFD_EA_ABS_CODE) begin
               dec.mode = ofd_pkg::OFD_EA_ABSOLUTE;
               dec.illegal = 1'b0;
            end
            if (ALLOW_IMM && field == ofd_pkg::OFD_EA_IMM_CODE) begin
               dec.mode = ofd_pkg::OFD_EA_IMMEDIATE;
               dec.illegal = 1'b0;
            end
         end
      endcase
   end

endmodule : ofd_ea_decode

// ===== ofd_decoder.sv
// Operand field decoder: registers decoded selects one cycle after the fields
//
// Functional notes
// - Source select: 001 opposite accumulator, 010 x, 011 y, 100-111 inputs.
// - Parallel fields: first 010/011 mids, second lows, third 000 opposite.
// - Data pair bit: 0 x pair, 1 y pair.
// - Two-bit source: 00 xl, 01 yl, 10 xh, 11 yh.
// - Controller byte: mode, condition, chip mode, extended mode.
// - Full address field: seven modes, absolute 110000, immediate 110100.
// - Second address variant: seven modes and absolute, no immediate.
// - Third address variant: only the seven register-indirect modes.
// - Short address field: two mode bits pick four post-update modes.
// - Low three bits index the address pointer zero to seven.
// - Memory space bit: 0 x memory, 1 y memory.
// - Six-bit register field decoded by prefix into eight groups.
// - Sub-codes: extension pointer 010, vector base 000, size counter 001.
// - Long move: pairs, limited single accumulators, cross pairs.
// - Address destination: leading 0 pointer, leading 1 offset register.
// - Three-bit multiplier pair: eight pairs, no high squares.
// - Single multiplier operand: yh, xl, yl, xh.
// - Alternate multiplier operand: xl, yl, xh, yh.
// - Multiply sign bit selects product sign, codes 0 and 1.
// - Four-bit multiplier pair: all sixteen pairs, first eight as three-bit.
`timescale 1ns/10ps
module ofd_decoder (
   input wire logic sys_clk, // Core clock
   input wire logic reset_n, // Asynchronous reset, active low
   input ofd_pkg::ofd_fields_s fields, // Operand fields from decode stage
   output ofd_pkg::ofd_dec_s dec // Registered decoded operands
);

   ofd_pkg::ofd_dec_s dec_nxt;
   ofd_pkg::ofd_dec_s dec_r;
   ofd_pkg::ofd_ea_s ea1_w;
   ofd_pkg::ofd_ea_s ea2_w;
   ofd_pkg::ofd_ea_s ea3_w;
   ofd_pkg::ofd_opnd_e opp_acc;
   ofd_pkg::ofd_opnd_e opp_src2;
   logic bad_src;
   logic bad_par;
   logic bad_reg;
   logic [9:0] mul_w;
   logic [9:0] wmul_w;

   // Every check below runs on the core clock and sleeps during reset
   default clocking chk_clk @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // ======================================================================
   // Effective-address variants
   // ======================================================================
   ofd_ea_decode #(.ALLOW_ABS(1'b1), .ALLOW_IMM(1'b1)) u_ea1 (
      .field(fields.ea1),
      .dec(ea1_w)
   );
   ofd_ea_decode #(.ALLOW_ABS(1'b1), .ALLOW_IMM(1'b0)) u_ea2 (
      .field(fields.ea2),
      .dec(ea2_w)
   );
   ofd_ea_decode #(.ALLOW_ABS(1'b0), .ALLOW_IMM(1'b0)) u_ea3 (
      .field(fields.ea3),
      .dec(ea3_w)
   );

   // Operand helpers: map of the common two-bit input order
   function automatic ofd_pkg::ofd_opnd_e inp_xy(input logic [1:0] c);
      unique case (c)
         2'h0: inp_xy = ofd_pkg::OFD_SEL_XL;
         2'h1: inp_xy = ofd_pkg::OFD_SEL_YL;
         2'h2: inp_xy = ofd_pkg::OFD_SEL_XH;
         2'h3: inp_xy = ofd_pkg::OFD_SEL_YH;
      endcase
   endfunction : inp_xy

   // ======================================================================
   // Accumulator and source fields
   // ======================================================================
   always_comb begin
      opp_acc = fields.dest_acc ? ofd_pkg::OFD_SEL_ACC_A
                                : ofd_pkg::OFD_SEL_ACC_B;
      opp_src2 = fields.dest_acc ? ofd_pkg::OFD_SEL_ACC_A
                                 : ofd_pkg::OFD_SEL_ACC_B;
   end

   always_comb begin
      dec_nxt = '0;
      bad_src = 1'b0;
      bad_par = 1'b0;
      bad_reg = 1'b0;
      dec_nxt.valid = fields.valid;
      dec_nxt.dest_acc = fields.dest_acc ? ofd_pkg::OFD_SEL_ACC_B
                                         : ofd_pkg::OFD_SEL_ACC_A;
      dec_nxt.data_pair = fields.data_pair ? ofd_pkg::OFD_SEL_Y
                                           : ofd_pkg::OFD_SEL_X;
      dec_nxt.src_two = inp_xy(fields.src_two);
      dec_nxt.pcu_byte = fields.pcu_byte;

      unique case (fields.src_sel)
         3'h0: begin
            dec_nxt.src_sel = ofd_pkg::OFD_SEL_NONE;
            bad_src = 1'b1;
         end
         3'h1: dec_nxt.src_sel = opp_acc;
         3'h2: dec_nxt.src_sel = ofd_pkg::OFD_SEL_X;
         3'h3: dec_nxt.src_sel = ofd_pkg::OFD_SEL_Y;
         default: dec_nxt.src_sel = inp_xy(fields.src_sel[1:0]);
      endcase

      // Upper half of the parallel fields is common to all three
      if (fields.par1[2]) begin
         dec_nxt.par1 = inp_xy(fields.par1[1:0]);
      end else begin
         unique case (fields.par1[1:0])
            2'h2: dec_nxt.par1 = ofd_pkg::OFD_SEL_A_MID;
            2'h3: dec_nxt.par1 = ofd_pkg::OFD_SEL_B_MID;
            default: begin
               dec_nxt.par1 = ofd_pkg::OFD_SEL_NONE;
               bad_par = 1'b1;
            end
         endcase
      end
      if (fields.par2[2]) begin
         dec_nxt.par2 = inp_xy(fields.par2[1:0]);
      end else begin
         unique case (fields.par2[1:0])
            2'h2: dec_nxt.par2 = ofd_pkg::OFD_SEL_A_LOW;
            2'h3: dec_nxt.par2 = ofd_pkg::OFD_SEL_B_LOW;
            default: begin
               dec_nxt.par2 = ofd_pkg::OFD_SEL_NONE;
               bad_par = 1'b1;
            end
         endcase
      end
      if (fields.par3[2]) begin
         dec_nxt.par3 = inp_xy(fields.par3[1:0]);
      end else if (fields.par3[1:0] == 2'h0) begin
         dec_nxt.par3 = opp_src2;
      end else begin
         dec_nxt.par3 = ofd_pkg::OFD_SEL_NONE;
         bad_par = 1'b1;
      end

      // ====================================================================
      // Effective addresses and memory space
      // ====================================================================
      dec_nxt.ea1 = ea1_w;
      dec_nxt.ea2 = ea2_w;
      dec_nxt.ea3 = ea3_w;
      dec_nxt.ea_short.ptr = fields.ea_short[2:0];
      dec_nxt.ea_short.illegal = 1'b0;
      unique case (fields.ea_short[4:3])
         2'h0: dec_nxt.ea_short.mode = ofd_pkg::OFD_EA_POSTDEC_OFS;
         2'h1: dec_nxt.ea_short.mode = ofd_pkg::OFD_EA_POSTINC_OFS;
         2'h2: dec_nxt.ea_short.mode = ofd_pkg::OFD_EA_POSTDEC;
         2'h3: dec_nxt.ea_short.mode = ofd_pkg::OFD_EA_POSTINC;
      endcase
      dec_nxt.mem_y = fields.mem_space;

      // ====================================================================
      // Six-bit on-chip register field
      // ====================================================================
      dec_nxt.reg_idx = {1'b0, fields.reg6[2:0]};
      unique case (fields.reg6[5:3])
         3'h0: begin
            if (fields.reg6[5:2] == ofd_pkg::OFD_ALU_IN_PREFIX) begin
               dec_nxt.reg_grp = ofd_pkg::OFD_GRP_ALU_IN;
               dec_nxt.reg_idx = {2'h0, fields.reg6[1:0]};
            end else begin
               dec_nxt.reg_grp = ofd_pkg::OFD_GRP_NONE;
               bad_reg = 1'b1;
            end
         end
         3'h1: dec_nxt.reg_grp = ofd_pkg::OFD_GRP_ACC;
         3'h2: dec_nxt.reg_grp = ofd_pkg::OFD_GRP_PTR;
         3'h3: dec_nxt.reg_grp = ofd_pkg::OFD_GRP_OFS;
         3'h4: dec_nxt.reg_grp = ofd_pkg::OFD_GRP_MOD;
         3'h5: begin
            if (fields.reg6[2:0] == ofd_pkg::OFD_EXT_PTR_CODE) begin
               dec_nxt.reg_grp = ofd_pkg::OFD_GRP_EXT_PTR;
               dec_nxt.reg_idx = ofd_pkg::OFD_CTL_STACK_EXT_PTR;
            end else begin
               dec_nxt.reg_grp = ofd_pkg::OFD_GRP_NONE;
               bad_reg = 1'b1;
            end
         end
         3'h6: begin
            if (fields.reg6[2:1] == 2'h0) begin
               dec_nxt.reg_grp = ofd_pkg::OFD_GRP_CTL2;
               dec_nxt.reg_idx = fields.reg6[0]
                  ? ofd_pkg::OFD_CTL_SIZE_COUNTER
                  : ofd_pkg::OFD_CTL_VECTOR_BASE;
            end else begin
               dec_nxt.reg_grp = ofd_pkg::OFD_GRP_NONE;
               bad_reg = 1'b1;
            end
         end
         3'h7: dec_nxt.reg_grp = ofd_pkg::OFD_GRP_CTL8;
      endcase

      // ====================================================================
      // Long move field
      // ====================================================================
      unique case (fields.long_move)
         3'h0: dec_nxt.long_move.pair = ofd_pkg::OFD_SEL_A10;
         3'h1: dec_nxt.long_move.pair = ofd_pkg::OFD_SEL_B10;
         3'h2: dec_nxt.long_move.pair = ofd_pkg::OFD_SEL_X;
         3'h3: dec_nxt.long_move.pair = ofd_pkg::OFD_SEL_Y;
         3'h4: dec_nxt.long_move.pair = ofd_pkg::OFD_SEL_ACC_A;
         3'h5: dec_nxt.long_move.pair = ofd_pkg::OFD_SEL_ACC_B;
         3'h6: dec_nxt.long_move.pair = ofd_pkg::OFD_SEL_AB;
         3'h7: dec_nxt.long_move.pair = ofd_pkg::OFD_SEL_BA;
      endcase
      dec_nxt.long_move.limit_src = fields.long_move[2];
      dec_nxt.long_move.sign_ext = fields.long_move[2];
      dec_nxt.long_move.zero_fill = fields.long_move[2] &
                                    fields.long_move[1];

      // Address destination
      dec_nxt.addr_is_ofs = fields.addr_dest[3];
      dec_nxt.addr_idx = fields.addr_dest[2:0];

      // ====================================================================
      // Multiplier operands
      // ====================================================================
      mul_w = mul_pair({1'b0, fields.mult_pair});
      wmul_w = mul_pair(fields.mult_wide);
      dec_nxt.mul_a = ofd_pkg::ofd_opnd_e'(mul_w[9:5]);
      dec_nxt.mul_b = ofd_pkg::ofd_opnd_e'(mul_w[4:0]);
      dec_nxt.wmul_a = ofd_pkg::ofd_opnd_e'(wmul_w[9:5]);
      dec_nxt.wmul_b = ofd_pkg::ofd_opnd_e'(wmul_w[4:0]);
      unique case (fields.mult_one)
         2'h0: dec_nxt.mul_one = ofd_pkg::OFD_SEL_YH;
         2'h1: dec_nxt.mul_one = ofd_pkg::OFD_SEL_XL;
         2'h2: dec_nxt.mul_one = ofd_pkg::OFD_SEL_YL;
         2'h3: dec_nxt.mul_one = ofd_pkg::OFD_SEL_XH;
      endcase
      dec_nxt.mul_alt = inp_xy(fields.mult_alt);
      dec_nxt.negate = fields.mult_sign;

      dec_nxt.illegal = fields.valid & (bad_src | bad_par | bad_reg |
                        ea1_w.illegal | ea2_w.illegal |
                        ea3_w.illegal);
   end

   // Sixteen multiplier pairs; the three-bit field uses the first eight
   function automatic logic [9:0] mul_pair(input logic [3:0] c);
      unique case (c)
         4'h0: mul_pair = {ofd_pkg::OFD_SEL_XL, ofd_pkg::OFD_SEL_XL};
         4'h1: mul_pair = {ofd_pkg::OFD_SEL_YL, ofd_pkg::OFD_SEL_YL};
         4'h2: mul_pair = {ofd_pkg::OFD_SEL_XH, ofd_pkg::OFD_SEL_XL};
         4'h3: mul_pair = {ofd_pkg::OFD_SEL_YH, ofd_pkg::OFD_SEL_YL};
         4'h4: mul_pair = {ofd_pkg::OFD_SEL_XL, ofd_pkg::OFD_SEL_YH};
         4'h5: mul_pair = {ofd_pkg::OFD_SEL_YL, ofd_pkg::OFD_SEL_XL};
         4'h6: mul_pair = {ofd_pkg::OFD_SEL_XH, ofd_pkg::OFD_SEL_YL};
         4'h7: mul_pair = {ofd_pkg::OFD_SEL_YH, ofd_pkg::OFD_SEL_XH};
         4'h8: mul_pair = {ofd_pkg::OFD_SEL_XH, ofd_pkg::OFD_SEL_XH};
         4'h9: mul_pair = {ofd_pkg::OFD_SEL_YH, ofd_pkg::OFD_SEL_YH};
         4'hA: mul_pair = {ofd_pkg::OFD_SEL_XL, ofd_pkg::OFD_SEL_XH};
         4'hB: mul_pair = {ofd_pkg::OFD_SEL_YL, ofd_pkg::OFD_SEL_YH};
         4'hC: mul_pair = {ofd_pkg::OFD_SEL_YH, ofd_pkg::OFD_SEL_XL};
         4'hD: mul_pair = {ofd_pkg::OFD_SEL_XL, ofd_pkg::OFD_SEL_YL};
         4'hE: mul_pair = {ofd_pkg::OFD_SEL_YL, ofd_pkg::OFD_SEL_XH};
         4'hF: mul_pair = {ofd_pkg::OFD_SEL_XH, ofd_pkg::OFD_SEL_YH};
      endcase
   endfunction : mul_pair

   // ======================================================================
   // Output register
   // ======================================================================
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dec_r <= '0;
      end else begin
         dec_r <= dec_nxt;
      end
   end

   assign dec = dec_r;

   // ======================================================================
   // Checks
   // ======================================================================
   chk_src_opposite: assert property (
      fields.src_sel == 3'h1 |=> (dec.src_sel == ofd_pkg::OFD_SEL_ACC_A) ==
      $past(fields.dest_acc))
      else $error("source select not opposite accumulator");
   chk_par_first: assert property (
      fields.par1 == 3'h2 |=> dec.par1 == ofd_pkg::OFD_SEL_A_MID)
      else $error("first parallel field 010 wrong");
   chk_data_pair: assert property (
      fields.data_pair |=> dec.data_pair == ofd_pkg::OFD_SEL_Y)
      else $error("data pair bit wrong");
   chk_ea_imm: assert property (
      fields.ea1 == 6'h34 |=> dec.ea1.mode == ofd_pkg::OFD_EA_IMMEDIATE)
      else $error("immediate code not decoded");
   chk_ea2_noimm: assert property (
      fields.valid && fields.ea2 == 6'h34 |=> dec.illegal)
      else $error("second variant accepted immediate");
   chk_ea3_noabs: assert property (
      fields.valid && fields.ea3 == 6'h30 |=> dec.illegal)
      else $error("third variant accepted absolute");
   chk_ea_ptr: assert property (
      ##1 dec.ea_short.ptr == $past(fields.ea_short[2:0]))
      else $error("pointer index mismatch");
   chk_reg_ctl2: assert property (
      fields.reg6 == 6'h31 |=> dec.reg_idx == ofd_pkg::OFD_CTL_SIZE_COUNTER)
      else $error("size counter code wrong");
   chk_long_zero: assert property (
      fields.long_move == 3'h5 |=> !dec.long_move.zero_fill &&
      dec.long_move.sign_ext)
      else $error("long move extension wrong");
   chk_mul_sq: assert property (
      fields.mult_wide == 4'h9 |=> dec.wmul_a == ofd_pkg::OFD_SEL_YH &&
      dec.wmul_b == ofd_pkg::OFD_SEL_YH)
      else $error("wide square code wrong");
   chk_mul_one: assert property (
      fields.mult_one == 2'h0 |=> dec.mul_one == ofd_pkg::OFD_SEL_YH)
      else $error("single multiplier code wrong");
   chk_src_reserved: assert property (
      fields.valid && fields.src_sel == 3'h0 |=> dec.illegal)
      else $error("reserved source select not flagged");
   chk_no_valid: assert property (
      !fields.valid |=> !dec.illegal)
      else $error("illegal flag without valid");
   chk_mem_space: assert property (
      fields.mem_space |=> dec.mem_y)
      else $error("memory space bit wrong");
   chk_addr_ofs: assert property (
      fields.addr_dest[3] |=> dec.addr_is_ofs)
      else $error("offset register destination wrong");
   chk_sign_negate: assert property (
      fields.mult_sign |=> dec.negate)
      else $error("negative sign code not applied");
   chk_dest_first: assert property (
      !fields.dest_acc |=> dec.dest_acc == ofd_pkg::OFD_SEL_ACC_A)
      else $error("destination accumulator wrong");
   chk_mul_pair: assert property (
      fields.mult_pair == 3'h7 |=> dec.mul_a == ofd_pkg::OFD_SEL_YH &&
      dec.mul_b == ofd_pkg::OFD_SEL_XH)
      else $error("three-bit multiplier pair wrong");

   cov_illegal: cover property (dec.illegal);
   cov_abs: cover property (dec.ea2.mode == ofd_pkg::OFD_EA_ABSOLUTE);
   cov_cross: cover property (dec.long_move.zero_fill);
   cov_imm: cover property (dec.ea1.mode == ofd_pkg::OFD_EA_IMMEDIATE);
   cov_ctl2: cover property (dec.reg_grp == ofd_pkg::OFD_GRP_CTL2);

endmodule : ofd_decoder

// ===== ofd_fetch_model.sv
// Fetch-stage stand-in that presents operand fields to the decoder
`timescale 1ns/10ps
module ofd_fetch_model (
   input ofd_pkg::ofd_fields_s nxt, // Fields chosen by the bench
   output ofd_pkg::ofd_fields_s fields // Fields toward the decoder
);
   // Passed straight through; the bench holds each word a full cycle so every edge samples one settled word
   assign fields = nxt;
endmodule : ofd_fetch_model

// ===== ofd_decoder_bench.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/10ps
module ofd_decoder_bench;
   typedef struct packed {
      logic [4:0] k;
      logic [5:0] c;
      logic [15:0] e;
      logic ill;
   } ofd_row_s;
   logic sys_clk;
   logic reset_n;
   ofd_pkg::ofd_fields_s nxt;
   ofd_pkg::ofd_fields_s fields;
   ofd_pkg::ofd_fields_s f0;
   ofd_pkg::ofd_dec_s dec;
   int n_mismatch;
   int comparisons;
   // ==================================================================
   // Table: field kind, code, expected select, expected illegal flag
   ofd_row_s rows [46] = '{
      '{0,6'h01,16'h8,0}, '{0,6'h02,16'h5,0}, '{0,6'h03,16'h6,0},
      '{0,6'h07,16'h4,0}, '{0,6'h00,16'h0,1}, '{1,6'h01,16'h0,1},
      '{1,6'h02,16'ha,0}, '{2,6'h03,16'hc,0}, '{3,6'h00,16'h8,0},
      '{3,6'h02,16'h0,1}, '{4,6'h2b,16'h5,0}, '{4,6'h30,16'h7,0},
      '{4,6'h34,16'h8,0}, '{4,6'h31,16'hf,1}, '{4,6'h07,16'h0,0},
      '{5,6'h30,16'h7,0}, '{5,6'h34,16'hf,1}, '{6,6'h3a,16'h6,0},
      '{6,6'h30,16'hf,1}, '{7,6'h0d,16'hd,0}, '{7,6'h1f,16'h1f,0},
      '{8,6'h07,16'h13,0}, '{8,6'h26,16'h56,0}, '{8,6'h2a,16'h6a,0},
      '{8,6'h31,16'h79,0}, '{8,6'h3f,16'h87,0},
      '{10,6'h00,16'h88,0}, '{10,6'h05,16'h46,0},
      '{10,6'h06,16'h7f,0}, '{11,6'h0a,16'ha,0},
      '{11,6'h07,16'h7,0}, '{12,6'h00,16'h21,0},
      '{12,6'h07,16'h82,0}, '{13,6'h08,16'h42,0},
      '{13,6'h09,16'h84,0}, '{13,6'h0f,16'h44,0},
      '{14,6'h00,16'h4,0}, '{14,6'h03,16'h2,0}, '{15,6'h00,16'h1,0},
      '{15,6'h02,16'h2,0}, '{16,6'h01,16'h3,0}, '{16,6'h02,16'h2,0},
      '{17,6'h3f,16'h3368,0}, '{17,6'h00,16'h0287,0},
      '{17,6'h12,16'h22a7,0}, '{17,6'h0d,16'h1347,0}
   };
   always #12.5 sys_clk = ~sys_clk;
   ofd_fetch_model fetch (.nxt(nxt), .fields(fields));
   ofd_decoder uut (.sys_clk(sys_clk), .reset_n(reset_n), .fields(fields),
      .dec(dec));
   // ==================================================================
   // Legal base word with one field replaced by the code under test
   function automatic ofd_pkg::ofd_fields_s apply(input logic [4:0] k,
      input logic [5:0] c);
      ofd_pkg::ofd_fields_s f;
      f = '0;
      f.valid = 1'b1;
      f.src_sel = 3'h4;
      f.par1 = 3'h4;
      f.par2 = 3'h4;
      f.par3 = 3'h4;
      f.reg6 = 6'h10;
      case (k)
         0: f.src_sel = c[2:0];
         1: f.par1 = c[2:0];
         2: f.par2 = c[2:0];
         3: f.par3 = c[2:0];
         4: f.ea1 = c;
         5: f.ea2 = c;
         6: f.ea3 = c;
         7: f.ea_short = c[4:0];
         8: f.reg6 = c;
         10: f.long_move = c[2:0];
         11: f.addr_dest = c[3:0];
         12: f.mult_pair = c[2:0];
         13: f.mult_wide = c[3:0];
         14: f.mult_one = c[1:0];
         15: f.mult_alt = c[1:0];
         16: f.src_two = c[1:0];
         default: {f.dest_acc, f.mult_sign, f.mem_space, f.data_pair,
            f.pcu_byte} = c;
      endcase
      return f;
   endfunction : apply
   function automatic logic [15:0] seen(input logic [4:0] k);
      case (k)
         0: return 16'(dec.src_sel);
         1: return 16'(dec.par1);
         2: return 16'(dec.par2);
         3: return 16'(dec.par3);
         4: return 16'(dec.ea1.mode);
         5: return 16'(dec.ea2.mode);
         6: return 16'(dec.ea3.mode);
         7: return 16'({dec.ea_short.mode, dec.ea_short.ptr});
         8: return 16'({dec.reg_grp, dec.reg_idx});
         10: return 16'(dec.long_move);
         11: return 16'({dec.addr_is_ofs, dec.addr_idx});
         12: return 16'({dec.mul_a, dec.mul_b});
         13: return 16'({dec.wmul_a, dec.wmul_b});
         14: return 16'(dec.mul_one);
         15: return 16'(dec.mul_alt);
         16: return 16'(dec.src_two);
         default: return 16'({dec.pcu_byte, dec.data_pair, dec.mem_y,
            dec.negate, dec.dest_acc});
      endcase
   endfunction : seen
   task automatic chk(input string name, input logic [15:0] e,
      input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, e, s);
      end
   endtask : chk
   task automatic cmp(input int i);
      chk("select", rows[i].e, seen(rows[i].k));
      chk("illegal", 16'(rows[i].ill), 16'(dec.illegal));
   endtask : cmp
   task automatic summarize;
      if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // ==================================================================
   // Back-to-back table run, then unqualified and mid-run reset cases
   initial begin
      sys_clk = 1'b0;
      reset_n = 1'b0;
      nxt = '0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("reset", 16'h0, 16'(|dec));
      @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 0; i <= 46; i++) begin
         @(posedge sys_clk);
         if (i < 46) nxt <= apply(rows[i].k, rows[i].c);
         @(negedge sys_clk);
         if (i > 0) cmp(i - 1);
      end
      f0 = apply(5'd0, 6'h00);
      f0.valid = 1'b0;
      @(posedge sys_clk);
      nxt <= f0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("unqualified illegal", 16'h0, 16'(dec.illegal));
      chk("reserved select", 16'h0, seen(5'd0));
      @(posedge sys_clk);
      reset_n <= 1'b0;
      #1;
      chk("mid reset", 16'h0, 16'(|dec));
      summarize();
   end
endmodule : ofd_decoder_bench
